// >>> rtl/speed_ctl_defs.svh
/*
 * Offsets, field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock; included by bare name.
 */
`ifndef SPEED_CTL_DEFS_SVH
`define SPEED_CTL_DEFS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ      10000000
`define LOOP_MS     16
`define LOOP_CYC    (`LOOP_MS * (`CLK_HZ / 1000))
`define BOOT_MS     1000
`define BOOT_CYC    (`BOOT_MS * (`CLK_HZ / 1000))
`define SLOW_MS     500
`define SLOW_CYC    (`SLOW_MS * (`CLK_HZ / 1000))
`define FAST_MS     100
`define FAST_CYC    (`FAST_MS * (`CLK_HZ / 1000))
`define LOST_MS     100
`define LOST_CYC    (`LOST_MS * (`CLK_HZ / 1000))
`define US_CYC      (`CLK_HZ / 1000000)
`define RC_MIN_US   12'd1000
`define RC_MID_US   12'd1500
`define RC_MAX_US   12'd2000
`define RC_LO_US    12'd800
`define RC_HI_US    12'd2200
// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define ADDR_CTRL   12'h000
`define ADDR_GAIN   12'h004
`define ADDR_SETPT  12'h008
`define ADDR_CMD    12'h00C
`define ADDR_STAT   12'h010
`define ADDR_POWER  12'h014
`define ADDR_RCCMD  12'h018
`define CTRL_SERIAL 0
`define CTRL_ENC    1
`define GAIN_RST    24'h100408
`define RESET_KEY   32'h00525354
`define PWR_MAX     8'sd127
`endif

// >>> rtl/speed_ctl_pkg.sv
/*
 * Types shared by the speed regulator.
 * Assumes speed_ctl_defs.svh supplies the numbers.
 */
package speed_ctl_pkg;
	// Signed 8-bit speed, command or power value
	typedef logic signed [7:0] cmd_t;
	// Indicator sequencer states
	typedef enum logic [1:0] {LED_BOOT, LED_MODE, LED_SOLID, LED_FAST}
		led_state_t;
endpackage

// >>> rtl/speed_ctl.sv
/*
 * Two-channel closed-loop speed regulator with status indicator,
 * fault latching and radio pulse command inputs, on an APB slave.
 * Assumes one 10 MHz clock; pins are asynchronous and synchronised
 * here; measured speeds come from logic on the same clock.
 */
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
`include "speed_ctl_defs.svh"
module speed_ctl #(
	parameter int LOOP_CYC = `LOOP_CYC,
	parameter int BOOT_CYC = `BOOT_CYC,
	parameter int SLOW_CYC = `SLOW_CYC,
	parameter int FAST_CYC = `FAST_CYC,
	parameter int LOST_CYC = `LOST_CYC
) (
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata_q,
	output logic                     pready_q,
	output logic                     pslverr_q,
	input  wire speed_ctl_pkg::cmd_t meas_a,
	input  wire speed_ctl_pkg::cmd_t meas_b,
	input  wire logic                over_temp,
	input  wire logic                over_volt,
	input  wire logic                under_volt,
	input  wire logic                dead_man,
	input  wire logic                stop_or_invert_input,
	input  wire logic                enc_err,
	input  wire logic                radio_pulse_in_first,
	input  wire logic                radio_pulse_in_second,
	input  wire logic                radio_pulse_in_third,
	output speed_ctl_pkg::cmd_t      pwr_a_q,
	output speed_ctl_pkg::cmd_t      pwr_b_q,
	output logic                     out_en_q,
	output logic [1:0]               acc_out_q,
	output logic                     led_q
);
	import speed_ctl_pkg::*;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Clamp a wide signed value to the power limits
	function automatic cmd_t sat8(input logic signed [27:0] v);
		if (v > 28'sd127)
			sat8 = `PWR_MAX;
		else if (v < -28'sd127)
			sat8 = -`PWR_MAX;
		else
			sat8 = v[7:0];
	endfunction
	// Saturating integral accumulate
	function automatic logic signed [15:0] isat(
		input logic signed [15:0] a,
		input logic signed [8:0]  e);
		logic signed [16:0] s;
		s = 17'(a) + 17'(e);
		if (s > 17'sd32767)
			isat = 16'sh7FFF;
		else if (s < -17'sd32767)
			isat = -16'sh7FFF;
		else
			isat = s[15:0];
	endfunction
	// Shared-gain PID sum; gains zero-extend into signed so >>> keeps the sign
	function automatic cmd_t pid(
		input logic signed [8:0]  e,
		input logic signed [8:0]  pe,
		input logic signed [15:0] ig,
		input logic [23:0]        g);
		logic signed [27:0] p;
		logic signed [27:0] i;
		logic signed [27:0] d;
		p = 28'(e) * $signed({20'h0, g[7:0]});
		i = (28'(ig) * $signed({20'h0, g[15:8]})) >>> 8;
		d = (28'(e) - 28'(pe))
			* $signed({20'h0, g[23:16]});
		pid = sat8((p + i + d) >>> 4);
	endfunction
	// Pulse width in microseconds to signed command
	function automatic cmd_t rc_scale(input logic [11:0] w);
		logic signed [27:0] d;
		d = 28'($signed({1'b0, w}))
			- 28'($signed({1'b0, `RC_MID_US}));
		rc_scale = sat8((d * 28'sd127) / 28'sd500);
	endfunction
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [8:0] sync1_q;   // First stage, read only by second
	logic [8:0] sync2_q;   // Safe copies of the pins
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 9'h000;
			sync2_q <= 9'h000;
		end else begin
			sync1_q <= {radio_pulse_in_third, radio_pulse_in_second,
				radio_pulse_in_first, enc_err, stop_or_invert_input,
				dead_man, under_volt, over_volt, over_temp};
			sync2_q <= sync1_q;
		end
	end
	logic       recov;     // Any recoverable fault
	logic [2:0] rc_pin;    // Synchronised radio inputs
	assign recov  = |sync2_q[3:0];
	assign rc_pin = sync2_q[8:6];

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [1:0]  ctrl_q;    // Serial mode, encoder fitted
	logic [23:0] gain_q;    // Shared D, I, P gains
	logic [15:0] setpt_q;   // Serial setpoints B, A
	logic        latched_q; // Latched output-off state
	logic        clr_key;   // Reset command written
	logic        acc_cyc;   // Access edge of a transfer
	cmd_t        rc_cmd_q [3];
	logic [2:0]  rc_ok_q;
	assign acc_cyc = psel & penable & pready_q;
	assign clr_key = acc_cyc & pwrite & (paddr == `ADDR_CMD)
		& (pwdata == `RESET_KEY) & ctrl_q[`CTRL_SERIAL];
	// Writes take effect at the access edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q  <= 2'h0;            // Radio mode
			gain_q  <= `GAIN_RST;       // One set for both
			setpt_q <= 16'h0000;
		end else if (acc_cyc & pwrite) begin
			if (paddr == `ADDR_CTRL)
				ctrl_q <= pwdata[1:0];
			else if (paddr == `ADDR_GAIN)
				gain_q <= pwdata[23:0];
			else if (paddr == `ADDR_SETPT)
				setpt_q <= pwdata[15:0];
		end
	end

	// One wait-free access: ready rises in the first access cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel & ~penable;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			if (psel & ~penable) begin
				if (paddr == `ADDR_CTRL)
					prdata_q <= {30'h0, ctrl_q};
				else if (paddr == `ADDR_GAIN)
					prdata_q <= {8'h00, gain_q};
				else if (paddr == `ADDR_SETPT)
					prdata_q <= {16'h0000, setpt_q};
				else if (paddr == `ADDR_CMD)
					prdata_q <= 32'h0000_0000;
				else if (paddr == `ADDR_STAT)
					prdata_q <= {24'h0, rc_ok_q, acc_out_q,
						latched_q, recov, out_en_q};
				else if (paddr == `ADDR_POWER)
					prdata_q <= {16'h0000, pwr_b_q, pwr_a_q};
				else if (paddr == `ADDR_RCCMD)
					prdata_q <= {8'h00, rc_cmd_q[2], rc_cmd_q[1],
						rc_cmd_q[0]};
				else
					pslverr_q <= 1'b1;  // Unmapped address
			end
		end
	end

	// ------------------------------------------------------------
	// Fault handling
	// ------------------------------------------------------------
	logic latch_set;   // Stop input or encoder error
	assign latch_set = sync2_q[4]
		| (sync2_q[5] & ctrl_q[`CTRL_ENC]);
	// Latch wins over a simultaneous clear
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			latched_q <= 1'b0;
		else if (latch_set)
			latched_q <= 1'b1;
		else if (clr_key)
			latched_q <= 1'b0;
	end
	// Output enable follows faults and radio validity
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			out_en_q <= 1'b0;
		else
			out_en_q <= ~latched_q & ~latch_set & ~recov
				& (ctrl_q[`CTRL_SERIAL] | &rc_ok_q[1:0]);
	end

	// ------------------------------------------------------------
	// Radio pulse capture
	// ------------------------------------------------------------
	logic [3:0]  us_cnt_q;   // Microsecond divider
	logic        us_tick;
	logic [2:0]  rc_prev_q;  // Previous pin level
	logic [11:0] rc_w_q  [3];
	logic [23:0] rc_idle_q [3];
	assign us_tick = (us_cnt_q == 4'(`US_CYC - 1));
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			us_cnt_q <= 4'h0;
		else if (us_tick)
			us_cnt_q <= 4'h0;
		else
			us_cnt_q <= us_cnt_q + 4'h1;
	end
	// Width measure, range check and loss watchdog per channel
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rc_prev_q <= 3'h0;
			rc_ok_q   <= 3'h0;
			for (int c = 0; c < 3; c++) begin
				rc_w_q[c]    <= 12'h000;
				rc_idle_q[c] <= 24'h000000;
				rc_cmd_q[c]  <= 8'sh00;
			end
		end else begin
			rc_prev_q <= rc_pin;
			for (int c = 0; c < 3; c++) begin
				if (rc_pin[c] & ~rc_prev_q[c])
					rc_w_q[c] <= {11'h000, us_tick};
				else if (rc_pin[c] & us_tick & ~&rc_w_q[c])
					rc_w_q[c] <= rc_w_q[c] + 12'h001;
				if (~rc_pin[c] & rc_prev_q[c]) begin
					rc_idle_q[c] <= 24'h000000;
					if (rc_w_q[c] < `RC_LO_US
						|| rc_w_q[c] > `RC_HI_US)
						rc_ok_q[c] <= 1'b0;
					else begin
						rc_ok_q[c]  <= 1'b1;
						rc_cmd_q[c] <= rc_scale(rc_w_q[c]);
					end
				end else if (rc_idle_q[c] >= 24'(LOST_CYC - 1))
					rc_ok_q[c] <= 1'b0;
				else
					rc_idle_q[c] <= rc_idle_q[c] + 24'h000001;
			end
		end
	end

	// Accessories follow the third channel while it is valid, in radio mode with no encoder fitted
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			acc_out_q <= 2'b00;
		else if (ctrl_q[`CTRL_SERIAL] | ctrl_q[`CTRL_ENC]
			| ~rc_ok_q[2])
			acc_out_q <= 2'b00;
		else
			acc_out_q <= {2{rc_cmd_q[2] > 8'sh00}};
	end
	// ------------------------------------------------------------
	// PID loop
	// ------------------------------------------------------------
	logic [23:0]        loop_cnt_q;
	logic               loop_tick;
	logic signed [8:0]  err_q   [2];   // Error of last period
	logic signed [15:0] integ_q [2];
	logic signed [8:0]  err_d   [2];
	cmd_t               des     [2];
	cmd_t               meas    [2];
	assign loop_tick = (loop_cnt_q == 24'(LOOP_CYC - 1));
	assign des[0]  = ctrl_q[`CTRL_SERIAL] ? setpt_q[7:0] : rc_cmd_q[0];
	assign des[1]  = ctrl_q[`CTRL_SERIAL] ? setpt_q[15:8] : rc_cmd_q[1];
	assign meas[0] = meas_a;
	assign meas[1] = meas_b;

	// Error of the current period
	always_comb begin
		for (int c = 0; c < 2; c++)
			err_d[c] = 9'(des[c]) - 9'(meas[c]);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			loop_cnt_q <= 24'h000000;
		else if (loop_tick)
			loop_cnt_q <= 24'h000000;
		else
			loop_cnt_q <= loop_cnt_q + 24'h000001;
	end

	// Integral grows while speed falls short, until it saturates at +/-32767
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < 2; c++) begin
				err_q[c]   <= 9'sh000;
				integ_q[c] <= 16'sh0000;
			end
		end else if (loop_tick) begin
			for (int c = 0; c < 2; c++) begin
				err_q[c] <= err_d[c];
				if (out_en_q)
					integ_q[c] <= isat(integ_q[c], err_d[c]);
			end
		end
	end

	// Power stage commands, zero while output is off
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pwr_a_q <= 8'sh00;
			pwr_b_q <= 8'sh00;
		end else if (~out_en_q) begin
			pwr_a_q <= 8'sh00;
			pwr_b_q <= 8'sh00;
		end else if (loop_tick) begin
			pwr_a_q <= pid(err_d[0], err_q[0], integ_q[0], gain_q);
			pwr_b_q <= pid(err_d[1], err_q[1], integ_q[1], gain_q);
		end
	end

	// ------------------------------------------------------------
	// Status indicator
	// ------------------------------------------------------------
	led_state_t  led_st_q;
	logic [23:0] led_cnt_q;
	logic [23:0] half;        // Half period of the blink
	assign half = (led_st_q == LED_FAST) ? 24'(FAST_CYC - 1)
		: ctrl_q[`CTRL_SERIAL] ? 24'(SLOW_CYC / 2 - 1)
		: 24'(SLOW_CYC - 1);
	// Boot delay, then mode flash, solid or fast flash
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			led_st_q  <= LED_BOOT;
			led_cnt_q <= 24'h000000;
			led_q     <= 1'b0;
		end else begin
			case (led_st_q)
				LED_BOOT: begin
					if (led_cnt_q >= 24'(BOOT_CYC - 1)) begin
						led_st_q  <= LED_MODE;
						led_cnt_q <= 24'h000000;
						led_q     <= 1'b1;   // First flash at once
					end else
						led_cnt_q <= led_cnt_q + 24'h000001;
				end
				default: begin
					if (latched_q)
						led_st_q <= LED_FAST;
					else if (recov)
						led_st_q <= LED_SOLID;
					else
						led_st_q <= LED_MODE;
					if (led_st_q == LED_SOLID)
						led_q <= 1'b1;
					else if (led_cnt_q >= half) begin
						led_cnt_q <= 24'h000000;
						led_q     <= ~led_q;
					end else
						led_cnt_q <= led_cnt_q + 24'h000001;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_err_sub: assert property (loop_tick |=> err_q[0] ==
		$past(err_d[0])) else $error("Error not sampled");
	a_pwr_sat: assert property (pwr_a_q != -8'sd128 &&
		pwr_b_q != -8'sd128) else $error("Power beyond limit");
	a_estop_latch: assert property (sync2_q[4] |=>
		latched_q ##1 !out_en_q) else $error("Stop not latched");
	a_enc_latch: assert property (sync2_q[5] && ctrl_q[1] |=>
		latched_q) else $error("Encoder error not latched");
	a_latch_hold: assert property (latched_q && !clr_key |=>
		latched_q && !out_en_q) else $error("Latch released");
	a_key_clear: assert property (clr_key && !latch_set |=>
		!latched_q) else $error("Reset command ignored");
	a_recov_off: assert property (recov |=> !out_en_q)
		else $error("Output on during fault");
	a_mode_reset: assert property ($rose(rstn) |->
		!ctrl_q[0]) else $error("Mode not radio at reset");
	a_acc_enc: assert property (ctrl_q[1] |=> acc_out_q ==
		2'b00) else $error("Accessory on with encoder");
	a_pwr_off: assert property (!out_en_q |=> pwr_a_q == 0
		&& pwr_b_q == 0) else $error("Power while disabled");
	a_solid_led: assert property (led_st_q == LED_SOLID ##1
		led_st_q == LED_SOLID |-> led_q) else $error("Led not solid");
	c_latch_clear: cover property (latched_q ##1 !latched_q);
	c_fast_flash: cover property (led_st_q == LED_FAST && led_q);
	c_rc_valid: cover property (&rc_ok_q[1:0] && out_en_q);
	c_full_power: cover property (pwr_a_q == `PWR_MAX);
endmodule

// >>> dv/radio_rx_model.sv
/*
 * Radio receiver model: three pulse trains, widths set in microseconds.
 * Assumes a 10 MHz clk_sys; the pulse line idles low between pulses.
 */
`timescale 1ns/1ns
module radio_rx_model (
	input  wire logic clk_sys,
	input  int        width [3],
	output logic [2:0] pulse
);
	// ------------------------------------------------------------
	// Pulse generators
	// ------------------------------------------------------------
	initial pulse = 3'h0;
	for (genvar g = 0; g < 3; g++) begin : gen_ch
		// High for the width, then a 500 us gap, forever
		initial begin : run
			int w;
			repeat (g * 300) @(posedge clk_sys);
			forever begin
				w = width[g];
				pulse[g] <= 1'b1;
				repeat (w * 10) @(posedge clk_sys);
				pulse[g] <= 1'b0;
				repeat (5000) @(posedge clk_sys);
			end
		end
	end
endmodule

// >>> dv/tb.sv
/*
 * Self-checking bench for speed_ctl: APB master, radio model, faults, PID.
 * Assumes rtl/ sources and dv/radio_rx_model.sv are compiled before it.
 */
`timescale 1ns/1ns
`include "speed_ctl_defs.svh"
module tb;
	import speed_ctl_pkg::*;
	localparam int LP = 64, BT = 100, SL = 40, FS = 10;
	logic        clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata_q, rd;
	logic        pready_q, pslverr_q, er, out_en_q, led_q;
	logic [3:0]  flt = 4'h0;   // over_temp .. dead_man
	logic        estop = 0, enc_err = 0;
	logic [2:0]  pulse;
	logic [1:0]  acc_out_q;
	cmd_t        meas_a = -127, meas_b = 127, pwr_a_q, pwr_b_q;
	int          width [3] = '{1000, 2000, 1750};
	int          error_cnt = 0, samples_checked = 0, cyc = 0;
	int          seed = 17666, n, ma, mb, prev;

	always #50 clk_sys = ~clk_sys;

	speed_ctl #(.LOOP_CYC(LP), .BOOT_CYC(BT), .SLOW_CYC(SL),
		.FAST_CYC(FS), .LOST_CYC(30000)) dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.meas_a(meas_a), .meas_b(meas_b), .over_temp(flt[0]),
		.over_volt(flt[1]), .under_volt(flt[2]), .dead_man(flt[3]),
		.stop_or_invert_input(estop), .enc_err(enc_err),
		.radio_pulse_in_first(pulse[0]), .radio_pulse_in_second(pulse[1]),
		.radio_pulse_in_third(pulse[2]), .pwr_a_q(pwr_a_q),
		.pwr_b_q(pwr_b_q), .out_en_q(out_en_q), .acc_out_q(acc_out_q),
		.led_q(led_q));

	radio_rx_model rx_u (.clk_sys(clk_sys), .width(width), .pulse(pulse));

	// ------------------------------------------------------------
	// Checking, reporting and the hang guard
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask

	task give_verdict;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Cut a hang short well above the expected run length
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			error_cnt++;
			give_verdict;
		end
	end

	// Reference PID with the integral gain at zero, saturated
	function automatic int pid(int e, int ep, int p, int d);
		int s;
		s = (e * p + (e - ep) * d) >>> 4;
		return s > 127 ? 127 : (s < -127 ? -127 : s);
	endfunction

	// Reference radio conversion from width in microseconds
	function automatic int rc(int w);
		return (w - 1500) * 127 / 500;
	endfunction

	// ------------------------------------------------------------
	// APB master: setup, access until pready, then release
	// ------------------------------------------------------------
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rdat, output logic err);
		int k;
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1;
		k = 0;
		// Read in the edge's own time step: the value that edge samples
		@(posedge clk_sys);
		while (pready_q !== 1'b1 && k < 50) begin
			k++;
			@(posedge clk_sys);
		end
		if (pready_q !== 1'b1) error_cnt++;
		rdat = prdata_q;
		err = pslverr_q;
		psel <= 0;
		penable <= 0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, rd, er);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] x, input string nm);
		apb(0, a, 32'h0, rd, er);
		chk(nm, rd, x);
	endtask

	task wt(input int k);
		repeat (k) @(negedge clk_sys);
	endtask

	// Measure cycles between two indicator toggles
	task per(input int x);
		logic l;
		int c;
		l = led_q;
		c = 0;
		while (led_q === l && c < 500) begin
			@(negedge clk_sys);
			c++;
		end
		l = led_q;
		c = 0;
		while (led_q === l && c < 500) begin
			@(negedge clk_sys);
			c++;
		end
		chk("led period", c, x);
	endtask

	task do_rst;
		rstn <= 0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		do_rst;
		wt(BT - 5);
		chk("boot dark", led_q, 0);
		n = 0;
		while (led_q !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		chk("boot end", n > 2 && n < 12, 1);
		per(SL);
		rdc(`ADDR_CTRL, 32'h0, "ctrl");
		rdc(`ADDR_GAIN, `GAIN_RST, "gain");
		apb(0, 12'hFFC, 32'h0, rd, er);
		chk("unmapped", er, 1);
		$display("test reset and boot done");
		wt(30000);
		rdc(`ADDR_RCCMD, {8'h0, 8'(rc(width[2])), 8'(rc(width[1])),
			8'(rc(width[0]))}, "radio cmd");
		rdc(`ADDR_STAT, 32'hF9, "stat radio");
		chk("acc on", acc_out_q, 3);
		wr(`ADDR_CTRL, 32'h2);
		wt(4);
		chk("acc enc", acc_out_q, 0);
		wr(`ADDR_CTRL, 32'h0);
		width[1] = 500;
		wt(31000);
		apb(0, `ADDR_STAT, 32'h0, rd, er);
		chk("rc bad", rd[7:5], 3'h5);
		chk("rc off", out_en_q, 0);
		width[1] = 2000;
		$display("test radio done");
		do_rst;
		wr(`ADDR_CTRL, 32'h1);
		wt(BT + 10);
		chk("serial on", out_en_q, 1);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			flt <= 4'(1 << i);
			wt(6);
			chk("recov off", out_en_q, 0);
			chk("recov led", led_q, 1);
			chk("recov pwr", pwr_a_q, 0);
			@(posedge clk_sys);
			flt <= 4'h0;
			wt(6);
			chk("recov back", out_en_q, 1);
		end
		per(SL / 2);
		@(posedge clk_sys);
		enc_err <= 1;
		wt(6);
		chk("enc unfitted", out_en_q, 1);
		wr(`ADDR_CTRL, 32'h3);
		wt(6);
		chk("enc latch", out_en_q, 0);
		@(posedge clk_sys);
		enc_err <= 0;
		per(FS);
		wt(50);
		chk("latch holds", out_en_q, 0);
		wr(`ADDR_CMD, `RESET_KEY);
		wt(5);
		chk("key clears", out_en_q, 1);
		@(posedge clk_sys);
		estop <= 1;
		wt(6);
		@(posedge clk_sys);
		estop <= 0;
		wt(30);
		chk("estop latch", out_en_q, 0);
		wr(`ADDR_CMD, `RESET_KEY);
		wt(5);
		chk("estop clear", out_en_q, 1);
		$display("test faults done");
		wr(`ADDR_SETPT, 32'h0000EC32);
		for (int j = 0; j < 2; j++) begin
			ma = $random(seed) % 40;
			mb = $random(seed) % 40;
			@(posedge clk_sys);
			meas_a <= cmd_t'(ma);
			meas_b <= cmd_t'(mb);
			wr(`ADDR_GAIN, j ? 32'hFF : 32'h8);
			wt(2 * LP + 4);
			chk("pwr a", pwr_a_q, pid(50 - ma, 50 - ma, j ? 255 : 8, 0));
			chk("pwr b", pwr_b_q, pid(-20 - mb, -20 - mb, j ? 255 : 8, 0));
		end
		wr(`ADDR_GAIN, 32'h100000);
		wt(2 * LP + 4);
		chk("diff idle", pwr_a_q, 0);
		@(posedge clk_sys);
		meas_a <= cmd_t'(ma + 30);
		n = 0;
		while (pwr_a_q === 8'h0 && n < LP + 8) begin
			@(negedge clk_sys);
			n++;
		end
		chk("diff kick", pwr_a_q, pid(20 - ma, 50 - ma, 0, 16));
		wt(LP + 2);
		chk("diff gone", pwr_a_q, 0);
		wr(`ADDR_GAIN, 32'hFF00);
		wr(`ADDR_SETPT, 32'h7F);
		@(posedge clk_sys);
		meas_a <= 0;
		prev = -128;
		for (int t = 0; t < 60; t++) begin
			wt(LP);
			if (pwr_a_q < prev) chk("ramp rise", pwr_a_q, prev);
			prev = pwr_a_q;
		end
		chk("ramp full", pwr_a_q, 127);
		$display("test pid done");
		give_verdict;
	end
endmodule
